// ===== hdl/sped_pkg.sv
package sped_pkg;
  localparam int unsigned SPED_ADDR_W = 4;
  localparam int unsigned SPED_DATA_W = 32;
  localparam int unsigned SPED_WORD_W = 8;
  localparam int unsigned SPED_CNT_W  = 4;

  // Register offsets
  localparam logic [SPED_ADDR_W-1:0] SPED_CTRL_OFS = 4'h0;
  localparam logic [SPED_ADDR_W-1:0] SPED_RXD_OFS  = 4'h4;
  localparam logic [SPED_ADDR_W-1:0] SPED_TXD_OFS  = 4'h8;

  // serial_port_control_reg fields
  localparam int unsigned SPED_RX_RST_N  = 0;
  localparam int unsigned SPED_RX_FIG    = 1;
  localparam int unsigned SPED_RX_IRQM   = 2;
  localparam int unsigned SPED_RX_DLY    = 4;
  localparam int unsigned SPED_RX_RDY    = 6;
  localparam int unsigned SPED_RX_OVR    = 7;
  localparam int unsigned SPED_RX_FSE    = 8;
  localparam int unsigned SPED_TX_RST_N  = 16;
  localparam int unsigned SPED_TX_FIG    = 17;
  localparam int unsigned SPED_TX_IRQM   = 18;
  localparam int unsigned SPED_TX_DLY    = 20;
  localparam int unsigned SPED_TX_RDY    = 22;
  localparam int unsigned SPED_TX_EMPTYN = 23;
  localparam int unsigned SPED_TX_FSE    = 24;
  localparam int unsigned SPED_TX_GEN    = 25;

  localparam logic [SPED_DATA_W-1:0] SPED_CFG_WMASK = 32'h023f_003f;
  localparam logic [SPED_DATA_W-1:0] SPED_CFG_RESET = 32'h0000_0000;

  localparam logic [1:0] SPED_IRQM_SYNCERR = 2'h3;

  // Synchronised pin vector layout
  localparam int unsigned SPED_PIN_W    = 5;
  localparam int unsigned SPED_PIN_RCLK = 0;
  localparam int unsigned SPED_PIN_RFS  = 1;
  localparam int unsigned SPED_PIN_RDIN = 2;
  localparam int unsigned SPED_PIN_TCLK = 3;
  localparam int unsigned SPED_PIN_TFS  = 4;
endpackage : sped_pkg

// ===== hdl/sped_core.sv
// Decided for this implementation: the address map and strobed register access.
`timescale 1ns/1ps
module sped_core
  import sped_pkg::*;
(
  input  wire logic                               clk_i,           // System clock
  input  wire logic                               sys_rst_i,       // Sync reset, active high
  input  wire logic [sped_pkg::SPED_ADDR_W-1:0]   reg_addr_i,      // Register address
  input  wire logic [sped_pkg::SPED_DATA_W-1:0]   reg_wdata_i,     // Write data
  input  wire logic                               reg_wr_i,        // Write strobe
  input  wire logic                               reg_rd_i,        // Read strobe
  output logic      [sped_pkg::SPED_DATA_W-1:0]   reg_rdata_o,     // Read data, next cycle
  input  wire logic                               rx_bit_clock_i,  // Receive bit clock pin
  input  wire logic                               rx_frame_sync_i, // Receive frame sync pin
  input  wire logic                               serial_in_i,     // Serial data in
  input  wire logic                               tx_bit_clock_i,  // Transmit bit clock pin
  input  wire logic                               tx_frame_sync_i, // Transmit frame sync pin
  output logic                                    serial_out_o,    // Serial data out
  output logic                                    rx_irq_o,        // Receive interrupt
  output logic                                    tx_irq_o,        // Transmit interrupt
  output logic                                    rx_dma_event_o,  // Receive data ready event
  output logic                                    tx_dma_event_o   // Transmit data wanted event
);
  import sped_pkg::*;

  localparam logic [SPED_CNT_W-1:0] CNT_WORD = SPED_CNT_W'(SPED_WORD_W);
  localparam logic [SPED_CNT_W-1:0] CNT_ONE  = 4'h1;
  localparam logic [SPED_CNT_W-1:0] CNT_ZERO = 4'h0;

  // Bits still owed to the current element exceed the data delay
  function automatic logic sped_late(input logic [SPED_CNT_W-1:0] d, input logic [SPED_CNT_W-1:0] b,
                                     input logic [1:0] dly);
    logic [SPED_CNT_W:0] rem;
    rem = {1'b0, d} + {1'b0, b};
    return rem > (SPED_CNT_W + 1)'(dly);
  endfunction : sped_late

  // Two-stage synchronisers plus one history stage for edge finding
  logic [SPED_PIN_W-1:0]  pin_s1_reg;
  logic [SPED_PIN_W-1:0]  pin_s2_reg;
  logic [SPED_PIN_W-1:0]  pin_s3_reg;
  logic [SPED_DATA_W-1:0] cfg_reg;
  logic [SPED_WORD_W-1:0] rx_shift_reg;
  logic [SPED_WORD_W-1:0] rx_buffer_reg;
  logic [SPED_WORD_W-1:0] rx_data_reg;
  logic                   rx_buf_full_reg;
  logic                   rx_ready_reg;
  logic                   rx_ovr_reg;
  logic                   rx_fse_reg;
  logic                   rx_fs_last_reg;
  logic [SPED_CNT_W-1:0]  rx_dcnt_reg;
  logic [SPED_CNT_W-1:0]  rx_bcnt_reg;
  logic [SPED_WORD_W-1:0] tx_data_reg;
  logic [SPED_WORD_W-1:0] tx_shift_reg;
  logic                   tx_ready_reg;
  logic                   tx_empty_n_reg;
  logic                   tx_fse_reg;
  logic                   tx_fs_last_reg;
  logic [SPED_CNT_W-1:0]  tx_dcnt_reg;
  logic [SPED_CNT_W-1:0]  tx_bcnt_reg;
  logic [SPED_DATA_W-1:0] ctrl_word;

  // Register decode
  wire wr_ctrl = reg_wr_i && (reg_addr_i == SPED_CTRL_OFS);
  wire wr_txd  = reg_wr_i && (reg_addr_i == SPED_TXD_OFS);
  wire rd_rxd  = reg_rd_i && (reg_addr_i == SPED_RXD_OFS);

  wire       rx_run  = cfg_reg[SPED_RX_RST_N];
  wire       rx_fig  = cfg_reg[SPED_RX_FIG];
  wire [1:0] rx_irqm = cfg_reg[SPED_RX_IRQM +: 2];
  wire [1:0] rx_dly  = cfg_reg[SPED_RX_DLY +: 2];
  wire       tx_run  = cfg_reg[SPED_TX_RST_N];
  wire       tx_fig  = cfg_reg[SPED_TX_FIG];
  wire [1:0] tx_irqm = cfg_reg[SPED_TX_IRQM +: 2];
  wire [1:0] tx_dly  = cfg_reg[SPED_TX_DLY +: 2];
  wire       tx_gen  = cfg_reg[SPED_TX_GEN];

  // Receive path: data sampled on falling bit clock edge
  wire rx_edge    = pin_s3_reg[SPED_PIN_RCLK] && !pin_s2_reg[SPED_PIN_RCLK];
  wire rx_fs_new  = rx_edge && pin_s2_reg[SPED_PIN_RFS] && !rx_fs_last_reg;
  wire rx_unexp   = sped_late(rx_dcnt_reg, rx_bcnt_reg, rx_dly);
  wire rx_start   = rx_fs_new && !(rx_unexp && rx_fig);
  wire rx_fse_evt = rx_run && rx_fs_new && rx_unexp && !rx_fig;
  wire [SPED_CNT_W-1:0] rx_d0 = rx_start ? SPED_CNT_W'(rx_dly) : rx_dcnt_reg;
  wire [SPED_CNT_W-1:0] rx_b0 = rx_start ? CNT_WORD : rx_bcnt_reg;
  wire rx_bit_now = rx_edge && (rx_d0 == CNT_ZERO) && (rx_b0 != CNT_ZERO);
  wire rx_done    = rx_run && rx_bit_now && (rx_b0 == CNT_ONE);
  wire [SPED_WORD_W-1:0] rx_word = {rx_shift_reg[SPED_WORD_W-2:0], pin_s2_reg[SPED_PIN_RDIN]};
  wire rx_copy    = rx_buf_full_reg && !rx_ready_reg;
  wire rx_to_buf  = rx_done && (!rx_buf_full_reg || rx_copy);
  wire rx_ovr_evt = rx_done && rx_buf_full_reg && rx_ready_reg;
  wire rx_resume  = rd_rxd && rx_ovr_reg && !rx_ovr_evt;

  // Transmit path: data launched on rising bit clock edge
  wire tx_edge    = !pin_s3_reg[SPED_PIN_TCLK] && pin_s2_reg[SPED_PIN_TCLK];
  wire tx_busy    = (tx_dcnt_reg != CNT_ZERO) || (tx_bcnt_reg != CNT_ZERO);
  wire tx_ext_fs  = pin_s2_reg[SPED_PIN_TFS] && !tx_fs_last_reg;
  wire tx_fs_src  = tx_gen ? (!tx_ready_reg && !tx_busy) : tx_ext_fs;
  wire tx_fs_new  = tx_run && tx_edge && tx_fs_src;
  wire tx_unexp   = sped_late(tx_dcnt_reg, tx_bcnt_reg, tx_dly);
  wire tx_fresh   = tx_fs_new && !tx_unexp;
  wire tx_restart = tx_fs_new && tx_unexp && !tx_fig;
  wire tx_copy    = tx_fresh && !tx_ready_reg;
  wire [SPED_CNT_W-1:0] tx_d0 = (tx_fresh || tx_restart) ? SPED_CNT_W'(tx_dly) : tx_dcnt_reg;
  wire [SPED_CNT_W-1:0] tx_b0 = (tx_fresh || tx_restart) ? CNT_WORD : tx_bcnt_reg;
  wire [SPED_WORD_W-1:0] tx_src = tx_fresh ? tx_data_reg : tx_shift_reg;
  wire tx_bit_now = tx_edge && (tx_d0 == CNT_ZERO) && (tx_b0 != CNT_ZERO);
  wire [2:0] tx_sel = 3'(tx_b0 - CNT_ONE);
  wire tx_last    = tx_run && tx_bit_now && (tx_b0 == CNT_ONE);

  // Status word assembly
  always_comb begin
    ctrl_word = cfg_reg;
    ctrl_word[SPED_RX_RDY] = rx_ready_reg;
    ctrl_word[SPED_RX_OVR] = rx_ovr_reg;
    ctrl_word[SPED_RX_FSE] = rx_fse_reg;
    ctrl_word[SPED_TX_RDY] = tx_ready_reg;
    ctrl_word[SPED_TX_EMPTYN] = tx_empty_n_reg;
    ctrl_word[SPED_TX_FSE] = tx_fse_reg;
  end

  assign rx_irq_o       = (rx_irqm == SPED_IRQM_SYNCERR) ? rx_fse_reg : rx_ready_reg;
  assign tx_irq_o       = (tx_irqm == SPED_IRQM_SYNCERR) ? tx_fse_reg : tx_ready_reg;
  assign rx_dma_event_o = rx_ready_reg;
  assign tx_dma_event_o = tx_run && tx_ready_reg;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
      pin_s3_reg <= '0;
    end else begin
      pin_s1_reg <= {tx_frame_sync_i, tx_bit_clock_i, serial_in_i, rx_frame_sync_i, rx_bit_clock_i};
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
    end
  end

  // Register port
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cfg_reg     <= SPED_CFG_RESET;
      reg_rdata_o <= '0;
    end else begin
      if (wr_ctrl)
        cfg_reg <= reg_wdata_i & SPED_CFG_WMASK;
      if (!reg_rd_i)
        reg_rdata_o <= '0;
      else if (reg_addr_i == SPED_CTRL_OFS)
        reg_rdata_o <= ctrl_word;
      else if (reg_addr_i == SPED_RXD_OFS)
        reg_rdata_o <= SPED_DATA_W'(rx_data_reg);
      else if (reg_addr_i == SPED_TXD_OFS)
        reg_rdata_o <= SPED_DATA_W'(tx_data_reg);
      else
        reg_rdata_o <= '0;
    end
  end

  // Receive element framing
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !rx_run || rx_resume) begin
      rx_dcnt_reg    <= CNT_ZERO;
      rx_bcnt_reg    <= CNT_ZERO;
      rx_fs_last_reg <= 1'b0;
    end else if (rx_edge) begin
      rx_fs_last_reg <= pin_s2_reg[SPED_PIN_RFS];
      if (rx_d0 != CNT_ZERO) begin
        rx_dcnt_reg <= rx_d0 - CNT_ONE;
        rx_bcnt_reg <= rx_b0;
      end else begin
        rx_dcnt_reg <= CNT_ZERO;
        rx_bcnt_reg <= (rx_b0 != CNT_ZERO) ? rx_b0 - CNT_ONE : CNT_ZERO;
      end
    end
  end

  // Receive data and flags
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rx_shift_reg    <= '0;
      rx_buffer_reg   <= '0;
      rx_data_reg     <= '0;
      rx_buf_full_reg <= 1'b0;
      rx_ready_reg    <= 1'b0;
      rx_ovr_reg      <= 1'b0;
      rx_fse_reg      <= 1'b0;
    end else if (!rx_run) begin
      rx_buf_full_reg <= 1'b0;
      rx_ready_reg    <= 1'b0;
      rx_ovr_reg      <= 1'b0;
      rx_fse_reg      <= 1'b0;
    end else begin
      if (rx_bit_now)
        rx_shift_reg <= rx_word;
      if (rx_to_buf)
        rx_buffer_reg <= rx_word;
      if (rx_copy)
        rx_data_reg <= rx_buffer_reg;
      if (rx_to_buf)
        rx_buf_full_reg <= 1'b1;
      else if (rx_copy)
        rx_buf_full_reg <= 1'b0;
      if (rx_copy)
        rx_ready_reg <= 1'b1;
      else if (rd_rxd)
        rx_ready_reg <= 1'b0;
      if (rx_ovr_evt)
        rx_ovr_reg <= 1'b1;
      else if (rd_rxd)
        rx_ovr_reg <= 1'b0;
      if (rx_fse_evt)
        rx_fse_reg <= 1'b1;
      else if (wr_ctrl)
        rx_fse_reg <= reg_wdata_i[SPED_RX_FSE];
    end
  end

  // Transmit element framing and output
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !tx_run) begin
      tx_dcnt_reg    <= CNT_ZERO;
      tx_bcnt_reg    <= CNT_ZERO;
      tx_fs_last_reg <= 1'b0;
      serial_out_o   <= 1'b0;
    end else if (tx_edge) begin
      tx_fs_last_reg <= pin_s2_reg[SPED_PIN_TFS];
      serial_out_o   <= tx_bit_now ? tx_src[tx_sel] : 1'b0;
      if (tx_d0 != CNT_ZERO) begin
        tx_dcnt_reg <= tx_d0 - CNT_ONE;
        tx_bcnt_reg <= tx_b0;
      end else begin
        tx_dcnt_reg <= CNT_ZERO;
        tx_bcnt_reg <= (tx_b0 != CNT_ZERO) ? tx_b0 - CNT_ONE : CNT_ZERO;
      end
    end
  end

  // Transmit data and flags
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      tx_data_reg    <= '0;
      tx_shift_reg   <= '0;
      tx_ready_reg   <= 1'b1;
      tx_empty_n_reg <= 1'b0;
      tx_fse_reg     <= 1'b0;
    end else begin
      if (wr_txd)
        tx_data_reg <= reg_wdata_i[SPED_WORD_W-1:0];
      else if (!tx_run)
        tx_data_reg <= '0;
      if (tx_fresh)
        tx_shift_reg <= tx_data_reg;
      if (wr_txd)
        tx_ready_reg <= 1'b0;
      else if (!tx_run || tx_copy)
        tx_ready_reg <= 1'b1;
      if (!tx_run)
        tx_empty_n_reg <= 1'b0;
      else if (tx_copy)
        tx_empty_n_reg <= 1'b1;
      else if (tx_last && tx_ready_reg)
        tx_empty_n_reg <= 1'b0;
      if (!tx_run)
        tx_fse_reg <= 1'b0;
      else if (tx_restart)
        tx_fse_reg <= 1'b1;
      else if (wr_ctrl)
        tx_fse_reg <= reg_wdata_i[SPED_TX_FSE];
    end
  end

  a_ovr_cause: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(rx_ovr_reg) |-> $past(rx_ready_reg) && $past(rx_buf_full_reg) && $past(rx_done))
    else $error("overrun set without full pipeline");

  a_copy_held: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    rx_ready_reg && !rd_rxd && rx_run |=> $stable(rx_data_reg))
    else $error("data register changed while unread");

  a_ovr_read_clr: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    rd_rxd && !rx_ovr_evt || !rx_run |=> !rx_ovr_reg)
    else $error("overrun not cleared by read or reset");

  a_rx_ign_quiet: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    rx_fig && !wr_ctrl && rx_run && !rx_fse_reg |=> !rx_fse_reg)
    else $error("receive sync error set while ignoring");

  a_rx_fse_rst: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !rx_run |=> !rx_fse_reg ##1 (!rx_fse_reg || $past(rx_run)))
    else $error("receive sync error survived reset");

  a_rx_irq_route: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    rx_irqm == SPED_IRQM_SYNCERR |-> rx_irq_o == rx_fse_reg)
    else $error("receive interrupt not routed from sync error");

  a_tx_overwrite: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    wr_txd |=> !tx_ready_reg && tx_data_reg == $past(reg_wdata_i[SPED_WORD_W-1:0]))
    else $error("transmit write not stored");

  a_tx_empty_rst: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !tx_run |=> !tx_empty_n_reg && tx_ready_reg || $past(wr_txd))
    else $error("transmit reset state wrong");

  a_tx_gen_quiet: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    tx_gen && tx_run && tx_ready_reg && !tx_busy && !wr_txd |=> !tx_busy)
    else $error("frame generated without new data");

  a_tx_fse_set: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    tx_restart |=> tx_fse_reg && (tx_bcnt_reg != CNT_ZERO || tx_dcnt_reg != CNT_ZERO))
    else $error("transmit sync error not flagged");

  a_rx_shift_in: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    rx_bit_now && rx_run |=> rx_shift_reg[0] == $past(pin_s2_reg[SPED_PIN_RDIN]))
    else $error("receive bit not shifted in");

  a_ovr_late: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !(rx_buf_full_reg && rx_ready_reg) |=> !$rose(rx_ovr_reg))
    else $error("overrun set before pipeline filled");

  a_rx_fse_set: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    rx_fse_evt |=> rx_fse_reg)
    else $error("receive sync error not flagged");

  a_rx_sync_abort: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    rx_fse_evt && !rx_resume && rx_dly != '0 |=> rx_bcnt_reg == CNT_WORD)
    else $error("receive element not restarted");

  a_rx_first_ok: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    rx_fs_new && rx_dcnt_reg == CNT_ZERO && rx_bcnt_reg == CNT_ZERO && !wr_ctrl |=> !$rose(rx_fse_reg))
    else $error("idle receive sync flagged as error");

  a_tx_resend: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    tx_fresh && tx_ready_reg |=> tx_shift_reg == $past(tx_data_reg))
    else $error("stale transmit data not resent");

  a_tx_empty_clr: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    tx_copy |=> tx_empty_n_reg)
    else $error("transmit empty not cleared on copy");

  a_tx_ign_quiet: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    tx_fig && !wr_ctrl && tx_run && !tx_fse_reg |=> !tx_fse_reg)
    else $error("transmit sync error set while ignoring");

  a_tx_first_ok: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    tx_fs_new && !tx_busy && !wr_ctrl |=> !$rose(tx_fse_reg))
    else $error("idle transmit sync flagged as error");

  a_tx_reset_data: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !tx_run && !wr_txd |=> tx_data_reg == '0)
    else $error("transmit data not zeroed in reset");

  a_tx_irq_route: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    tx_irqm == SPED_IRQM_SYNCERR |-> tx_irq_o == tx_fse_reg)
    else $error("transmit interrupt not routed from sync error");
endmodule : sped_core

// ===== bench/sped_link_model.sv
`timescale 1ns/1ps
module sped_link_model (
  output logic      rx_bit_clock_o,  // Receive bit clock
  output logic      rx_frame_sync_o, // Receive frame sync
  output logic      serial_in_o,     // Data toward the port
  output logic      tx_bit_clock_o,  // Transmit bit clock
  output logic      tx_frame_sync_o, // Transmit frame sync
  input  wire logic serial_out_i     // Data from the port
);
  logic bclk = 1'b0;
  logic fs   = 1'b0;
  logic din  = 1'b0;

  assign rx_bit_clock_o  = bclk;
  assign tx_bit_clock_o  = bclk;
  assign rx_frame_sync_o = fs;
  assign tx_frame_sync_o = fs;
  assign serial_in_o     = din;

  // One frame, clock still outside it; a second sync at cycle rs restarts unless keep
  task automatic frame(input logic [7:0] rxd, input int dly, input int rs, input bit keep,
                       input bit sync_on, output logic [7:0] txq);
    int base;
    int k;
    int b;
    base = 0;
    txq  = 8'h00;
    for (k = 0; k < base + dly + 8; k++) begin
      if (k == rs && !keep) base = rs;
      b   = k - base - dly;
      fs  = sync_on && (k == 0 || k == rs);
      din = (b >= 0 && b < 8) ? rxd[7-b] : ~din;
      #5 bclk = 1'b1;
      #40 bclk = 1'b0;
      #35;
      if (b >= 0 && b < 8) txq[7-b] = serial_out_i;
    end
    fs  = 1'b0;
    din = ~din;
    #300;
  endtask : frame
endmodule : sped_link_model

// ===== bench/test_serial_port_error_detection.sv
`timescale 1ns/1ps
module test_serial_port_error_detection;
  import sped_pkg::*;
  localparam logic [31:0] cfg_on = 32'h0011_0011;
  logic        clk_i       = 1'b0;
  logic        sys_rst_i   = 1'b1;
  logic [3:0]  reg_addr_i  = 4'h0;
  logic [31:0] reg_wdata_i = 32'h0;
  logic        reg_wr_i    = 1'b0;
  logic        reg_rd_i    = 1'b0;
  logic [31:0] reg_rdata_o;
  logic        rclk, rfs, sin, tclk, tfs, sout, rx_irq_o, tx_irq_o, rx_dma_event_o, tx_dma_event_o;
  logic [7:0]  q;
  int          fail_count  = 0;
  int          checks      = 0;
  int          cycles      = 0;

  always #5 clk_i = ~clk_i;

  sped_core sped_core_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .rx_bit_clock_i(rclk), .rx_frame_sync_i(rfs), .serial_in_i(sin), .tx_bit_clock_i(tclk),
    .tx_frame_sync_i(tfs), .serial_out_o(sout), .rx_irq_o(rx_irq_o), .tx_irq_o(tx_irq_o),
    .rx_dma_event_o(rx_dma_event_o), .tx_dma_event_o(tx_dma_event_o));
  sped_link_model sped_link_model_inst (.rx_bit_clock_o(rclk), .rx_frame_sync_o(rfs),
    .serial_in_o(sin), .tx_bit_clock_o(tclk), .tx_frame_sync_o(tfs), .serial_out_i(sout));

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge clk_i);
    reg_wr_i    <= 1'b0;
    #1;
  endtask : wr

  task automatic rchk(input string name, input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge clk_i);
    reg_rd_i   <= 1'b0;
    #1 chk(name, e, reg_rdata_o & m);
  endtask : rchk

  task automatic cfg(input logic [31:0] v);
    wr(SPED_CTRL_OFS, 32'h0);
    wr(SPED_CTRL_OFS, v);
  endtask : cfg

  task automatic frame(input logic [7:0] d, input int rs, input bit keep, input bit sync_on);
    sped_link_model_inst.frame(d, 1, rs, keep, sync_on, q);
  endtask : frame

  task automatic t_reset();
    rchk("ctrl after reset", SPED_CTRL_OFS, 32'hffff_ffff, 32'h0040_0000);
    chk("tx irq after reset", 32'h1, {31'h0, tx_irq_o});
    chk("tx dma after reset", 32'h0, {31'h0, tx_dma_event_o});
    cfg(cfg_on);
    wr(4'hc, 32'hffff_ffff);
    wr(SPED_RXD_OFS, 32'hffff_ffff);
    rchk("unmapped read", 4'hc, 32'hffff_ffff, 32'h0);
    rchk("ctrl after enable", SPED_CTRL_OFS, 32'hffff_ffff, 32'h0051_0011);
    chk("tx dma after enable", 32'h1, {31'h0, tx_dma_event_o});
    $display("test reset done");
  endtask : t_reset

  task automatic t_tx_basic();
    cfg(cfg_on);
    rchk("tx sync error after toggle", SPED_CTRL_OFS, 32'h0100_0000, 32'h0);
    frame(8'h3c, 0, 1'b0, 1'b1);
    chk("tx before load", 32'h0, {24'h0, q});
    rchk("rx element", SPED_RXD_OFS, 32'hffff_ffff, 32'h3c);
    wr(SPED_TXD_OFS, 32'h5a);
    wr(SPED_TXD_OFS, 32'ha5);
    chk("tx dma after load", 32'h0, {31'h0, tx_dma_event_o});
    rchk("tx data readback", SPED_TXD_OFS, 32'hffff_ffff, 32'ha5);
    frame(8'h00, 0, 1'b0, 1'b1);
    chk("tx overwritten", 32'ha5, {24'h0, q});
    rchk("tx empty after shift", SPED_CTRL_OFS, 32'h0080_0000, 32'h0);
    frame(8'h00, 0, 1'b0, 1'b1);
    chk("tx stale resend", 32'ha5, {24'h0, q});
    $display("test tx basic done");
  endtask : t_tx_basic

  task automatic t_overrun();
    cfg(cfg_on);
    frame(8'h11, 0, 1'b0, 1'b1);
    chk("rx irq on ready", 32'h1, {31'h0, rx_irq_o});
    chk("rx dma on ready", 32'h1, {31'h0, rx_dma_event_o});
    frame(8'h22, 0, 1'b0, 1'b1);
    rchk("no overrun yet", SPED_CTRL_OFS, 32'h80, 32'h0);
    frame(8'h33, 0, 1'b0, 1'b1);
    rchk("overrun flag", SPED_CTRL_OFS, 32'h80, 32'h80);
    rchk("first element kept", SPED_RXD_OFS, 32'hffff_ffff, 32'h11);
    rchk("overrun cleared", SPED_CTRL_OFS, 32'h80, 32'h0);
    rchk("second element", SPED_RXD_OFS, 32'hffff_ffff, 32'h22);
    $display("test overrun done");
  endtask : t_overrun

  task automatic t_sync(input bit ign);
    cfg(cfg_on | (ign ? 32'h0002_0002 : 32'h0));
    wr(SPED_TXD_OFS, 32'hc3);
    frame(8'h96, 4, ign, 1'b1);
    chk("tx across sync", 32'hc3, {24'h0, q});
    rchk("rx across sync", SPED_RXD_OFS, 32'hff, 32'h96);
    rchk("sync errors", SPED_CTRL_OFS, 32'h0100_0100, ign ? 32'h0 : 32'h0100_0100);
    if (!ign) begin
      wr(SPED_CTRL_OFS, cfg_on | 32'h010c_010c);
      chk("rx irq from error", 32'h1, {31'h0, rx_irq_o});
      chk("tx irq from error", 32'h1, {31'h0, tx_irq_o});
      wr(SPED_CTRL_OFS, cfg_on | 32'h000c_000c);
      chk("rx irq after clear", 32'h0, {31'h0, rx_irq_o});
      chk("tx irq after clear", 32'h0, {31'h0, tx_irq_o});
      wr(SPED_CTRL_OFS, cfg_on | 32'h0100_0100);
      rchk("errors set by write", SPED_CTRL_OFS, 32'h0100_0100, 32'h0100_0100);
    end
    $display("test sync ignore %0d done", ign);
  endtask : t_sync

  task automatic t_gen();
    cfg(cfg_on | 32'h0200_0000);
    wr(SPED_TXD_OFS, 32'h3e);
    frame(8'h00, 0, 1'b0, 1'b0);
    chk("generated sync element", 32'h3e, {24'h0, q});
    frame(8'h00, 0, 1'b0, 1'b1);
    chk("no sync without data", 32'h0, {24'h0, q});
    $display("test generated sync done");
  endtask : t_gen

  task automatic t_delay();
    cfg(32'h0021_0021);
    rchk("delay fields", SPED_CTRL_OFS, 32'h0030_0030, 32'h0020_0020);
    wr(SPED_TXD_OFS, 32'h69);
    sped_link_model_inst.frame(8'ha7, 2, 0, 1'b0, 1'b1, q);
    chk("tx with delay two", 32'h69, {24'h0, q});
    rchk("rx with delay two", SPED_RXD_OFS, 32'hffff_ffff, 32'ha7);
    rchk("no error with delay two", SPED_CTRL_OFS, 32'h0100_0100, 32'h0);
    $display("test data delay done");
  endtask : t_delay

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : final_report

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      final_report();
    end
  end

  initial begin
    repeat (3) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    t_reset();
    t_tx_basic();
    t_overrun();
    t_sync(1'b1);
    t_sync(1'b0);
    t_gen();
    t_delay();
    final_report();
  end
endmodule : test_serial_port_error_detection
